// [src/irc_change_detector.sv]
`timescale 1ns/1ps
module irc_change_detector
  import irc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic              load,
  output logic      [ADDR_W-1:0] latchedAddr,
  output logic                   addrChangeN
);

  // ----------------------------------------------------------------
  // Held address and comparison
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] sameBits;

  assign sameBits    = ~(latchedAddr ^ addrIn);
  assign addrChangeN = &sameBits;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      latchedAddr <= '0;
    else if (load)
      latchedAddr <= addrIn;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_change_line_low: assert property (@(posedge ref_clk) disable iff (srst)
    (latchedAddr != addrIn) |-> !addrChangeN)
    else $error("change line not low on mismatch");

  chk_release_after_load: assert property (@(posedge ref_clk) disable iff (srst)
    load ##1 $stable(addrIn) |-> addrChangeN)
    else $error("change line not released after load");

endmodule : irc_change_detector

// [src/irc_pkg.sv]
// Contract
// - The change detector compares the held address with the incoming one and pulls the change line low on any mismatch.
// - A new address is loaded only while board select is low and no write pulse is reaching the array.
// - After loading, the comparison reports equality and the change line returns high.
// - An eight-signal selector routes row address, chip selects and read/write from the host side or the refresh side.
// - An accepted change stores the address, restarts the oscillator and clears the refresh flip-flop for host access.
// - Each accepted address starts one full oscillator period of address-to-write time plus write pulse width.
// - With no new address by the end of that period the refresh flip-flop enters the refresh state.
// - Refresh continues, row after row, until an address change is detected and accepted.
// - Thirty-two undisturbed periods refresh every cell of the array.
// - During refresh chip selects stay high, a binary counter walks all 32 rows, and each row gets a write pulse.
// - A row whose refresh is cut short by a host address stays in the counter and is applied first on resumption.
// - Disabled chip selects keep data off the outputs so a refresh write only restores the stored contents.
package irc_pkg;

  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 11;
  localparam int ROW_W    = 5;
  localparam int COL_W    = 5;
  localparam int ROW_LSB  = 0;
  localparam int COL_LSB  = 5;
  localparam int BANK_BIT = 10;
  localparam int CS_W     = 2;

  localparam logic [ROW_W-1:0] ROW_ZERO = 5'h00;
  localparam logic [ROW_W-1:0] ROW_LAST = 5'h1f;
  localparam logic [ROW_W-1:0] ROW_ONE  = 5'h01;
  localparam logic [CS_W-1:0]  CS_OFF   = 2'h3;
  localparam logic [CS_W-1:0]  CS_BANK0 = 2'h2;
  localparam logic [CS_W-1:0]  CS_BANK1 = 2'h1;
  localparam logic             RW_READ  = 1'h1;
  localparam logic             RW_WRITE = 1'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 200;
  localparam int T_AW_NS     = 150;
  localparam int T_WP_NS     = 100;
  localparam int AW_CYC      = (T_AW_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC      = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int OSC_CYC     = AW_CYC + WP_CYC;
  localparam int OSC_W       = 8;
  localparam int T_WINDOW_MS = 2;
  localparam int WINDOW_CYC  = T_WINDOW_MS * CLK_MHZ * 1000;
  localparam int WIN_W       = 20;

  localparam logic [OSC_W-1:0] OSC_ZERO = 8'h00;
  localparam logic [OSC_W-1:0] OSC_ONE  = 8'h01;
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_CYC - 1);
  localparam logic [OSC_W-1:0] OSC_WP   = OSC_W'(AW_CYC);

  typedef enum logic [1:0]
  {
    IRC_HOST    = 2'b01,
    IRC_REFRESH = 2'b10
  } irc_mode_e;

  // Active-low chip select for one of two banks
  function automatic logic [CS_W-1:0] irc_bank_sel(input logic bank);
    irc_bank_sel = bank ? CS_BANK1 : CS_BANK0;
  endfunction : irc_bank_sel

endpackage : irc_pkg

// [src/irc_refresh_controller.sv]
`timescale 1ns/1ps
module irc_refresh_controller
  import irc_pkg::*;
#(
  parameter int WINDOW_CYCLES = WINDOW_CYC
)
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] hostAddr,
  input  wire logic              boardSelectN,
  input  wire logic              hostRdWr,
  output logic      [ROW_W-1:0]  ramRow,
  output logic      [COL_W-1:0]  ramCol,
  output logic      [CS_W-1:0]   ramCsN,
  output logic                   ramRdWr,
  output logic                   refreshActive,
  output logic                   addressChangeLineN,
  output logic                   sweepDone,
  output logic                   refreshOverdue
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addrMeta;
  logic [ADDR_W-1:0] addrSync;
  logic              bsnMeta;
  logic              bsnSync;
  logic              rwMeta;
  logic              rwSync;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      addrMeta <= '0;
      addrSync <= '0;
      bsnMeta  <= 1'h1;
      bsnSync  <= 1'h1;
      rwMeta   <= RW_READ;
      rwSync   <= RW_READ;
    end
    else
    begin
      addrMeta <= hostAddr;
      addrSync <= addrMeta;
      bsnMeta  <= boardSelectN;
      bsnSync  <= bsnMeta;
      rwMeta   <= hostRdWr;
      rwSync   <= rwMeta;
    end
  end

  // ----------------------------------------------------------------
  // Address change detector
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] latchedAddr;
  logic              addrChangeN;
  logic              accept;

  // Only load while nothing writes the array, else a write could land on a moving row
  assign accept = !addrChangeN && !bsnSync && (ramRdWr == RW_READ);

  irc_change_detector u_detector
  (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .addrIn      (addrSync),
    .load        (accept),
    .latchedAddr (latchedAddr),
    .addrChangeN (addrChangeN)
  );

  // ----------------------------------------------------------------
  // Oscillator and refresh flip-flop
  // ----------------------------------------------------------------
  irc_mode_e         mode;
  irc_mode_e         next_mode;
  logic [OSC_W-1:0]  oscCnt;
  logic [OSC_W-1:0]  next_oscCnt;
  logic              oscEnd;
  logic              inWritePulse;

  assign oscEnd       = (oscCnt == OSC_LAST);
  assign inWritePulse = (oscCnt >= OSC_WP);
  // Restart on accept keeps the period aligned to the host's address
  assign next_oscCnt  = (accept || oscEnd) ? OSC_ZERO : oscCnt + OSC_ONE;

  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      IRC_HOST:
      begin
        if (!accept && oscEnd)
          next_mode = IRC_REFRESH;
      end
      IRC_REFRESH:
      begin
        if (accept)
          next_mode = IRC_HOST;
      end
      default:
        next_mode = IRC_HOST;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      mode   <= IRC_HOST;
      oscCnt <= OSC_ZERO;
    end
    else
    begin
      mode   <= next_mode;
      oscCnt <= next_oscCnt;
    end
  end

  // ----------------------------------------------------------------
  // Refresh row counter
  // ----------------------------------------------------------------
  logic [ROW_W-1:0] refRow;
  logic [ROW_W-1:0] next_refRow;
  logic             rowDone;
  logic             wrapNow;

  // A row only counts once its whole period ran; a cut-short row is redone
  assign rowDone     = (mode == IRC_REFRESH) && oscEnd && !accept;
  assign wrapNow     = rowDone && (refRow == ROW_LAST);
  assign next_refRow = wrapNow ? ROW_ZERO
                     : rowDone ? refRow + ROW_ONE
                     : refRow;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      refRow <= ROW_ZERO;
    else
      refRow <= next_refRow;
  end

  // ----------------------------------------------------------------
  // Eight-signal selector
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] hostView;
  logic [ROW_W-1:0]  next_ramRow;
  logic [COL_W-1:0]  next_ramCol;
  logic [CS_W-1:0]   next_ramCsN;
  logic              next_ramRdWr;
  logic              refreshSel;
  logic [CS_W-1:0]   hostCsN;
  logic              refreshRw;

  assign refreshSel   = (next_mode == IRC_REFRESH);
  // New address goes straight through so the access is not a cycle stale
  assign hostView     = accept ? addrSync : latchedAddr;
  assign hostCsN      = bsnSync ? CS_OFF : irc_bank_sel(hostView[BANK_BIT]);
  assign refreshRw    = inWritePulse ? RW_WRITE : RW_READ;
  assign next_ramRow  = refreshSel ? next_refRow : hostView[ROW_LSB +: ROW_W];
  assign next_ramCsN  = refreshSel ? CS_OFF : hostCsN;
  assign next_ramRdWr = (mode == IRC_REFRESH && !accept) ? refreshRw
                      : (bsnSync ? RW_READ : rwSync);
  assign next_ramCol  = hostView[COL_LSB +: COL_W];

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ramRow        <= ROW_ZERO;
      ramCol        <= '0;
      ramCsN        <= CS_OFF;
      ramRdWr       <= RW_READ;
      refreshActive <= 1'h0;
    end
    else
    begin
      ramRow        <= next_ramRow;
      ramCol        <= next_ramCol;
      ramCsN        <= next_ramCsN;
      ramRdWr       <= next_ramRdWr;
      refreshActive <= refreshSel;
    end
  end

  assign addressChangeLineN = addrChangeN;

  // ----------------------------------------------------------------
  // Sweep tracking
  // ----------------------------------------------------------------
  // Overdue only warns; the host alone can free time for a sweep
  logic [WIN_W-1:0] sinceSweep;
  logic             windowHit;

  assign windowHit = (sinceSweep >= WIN_W'(WINDOW_CYCLES));

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sinceSweep     <= '0;
      sweepDone      <= 1'h0;
      refreshOverdue <= 1'h0;
    end
    else
    begin
      sweepDone      <= wrapNow;
      refreshOverdue <= windowHit;
      if (wrapNow)
        sinceSweep <= '0;
      else if (!windowHit)
        sinceSweep <= sinceSweep + WIN_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_load_gated: assert property (@(posedge ref_clk) disable iff (srst)
    ($changed(latchedAddr) && !$past(srst)) |-> $past(!bsnSync && ramRdWr == RW_READ))
    else $error("address loaded while gated off");

  chk_latch_equal: assert property (@(posedge ref_clk) disable iff (srst)
    accept |=> latchedAddr == $past(addrSync))
    else $error("latched address differs from accepted one");

  chk_accept_clears: assert property (@(posedge ref_clk) disable iff (srst)
    accept |=> mode == IRC_HOST && oscCnt == OSC_ZERO)
    else $error("accept did not clear refresh and restart oscillator");

  chk_full_period: assert property (@(posedge ref_clk) disable iff (srst)
    (accept ##1 !accept [*3]) |-> oscCnt == OSC_W'(2))
    else $error("oscillator period not started at accept");

  chk_enter_refresh: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(mode == IRC_REFRESH) |-> $past(oscCnt) == OSC_LAST && !$past(accept))
    else $error("refresh entered off the period end");

  chk_stay_refresh: assert property (@(posedge ref_clk) disable iff (srst)
    (mode == IRC_REFRESH && !accept) |=> mode == IRC_REFRESH)
    else $error("refresh left without an accepted change");

  chk_cs_disabled: assert property (@(posedge ref_clk) disable iff (srst)
    refreshActive |-> ramCsN == CS_OFF && ramRow == refRow)
    else $error("chip select or row wrong during refresh");

  chk_row_held: assert property (@(posedge ref_clk) disable iff (srst)
    (mode == IRC_REFRESH && accept) |=> refRow == $past(refRow))
    else $error("interrupted row not kept");

  chk_row_wrap: assert property (@(posedge ref_clk) disable iff (srst)
    (rowDone && refRow == ROW_LAST) |=> refRow == ROW_ZERO)
    else $error("row counter did not wrap");

  chk_sweep_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    sweepDone |-> $past(refRow) == ROW_LAST && $past(rowDone))
    else $error("sweep reported without last row");

  chk_refresh_write: assert property (@(posedge ref_clk) disable iff (srst)
    (refreshActive && !ramRdWr) |-> ramCsN == CS_OFF)
    else $error("refresh write with chip enabled");

  chk_gate_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (!addrChangeN && (bsnSync || ramRdWr == RW_WRITE)) |=> $stable(latchedAddr))
    else $error("address taken while gated off");

  chk_host_route: assert property (@(posedge ref_clk) disable iff (srst)
    accept |=> !refreshActive && ramRow == $past(addrSync[ROW_LSB +: ROW_W])
               && ramCol == $past(addrSync[COL_LSB +: COL_W]))
    else $error("accepted address not routed to the array");

  chk_refresh_route: assert property (@(posedge ref_clk) disable iff (srst)
    (mode == IRC_REFRESH && !accept) |=> refreshActive && ramCsN == CS_OFF)
    else $error("selector left the refresh side");

  chk_period_end: assert property (@(posedge ref_clk) disable iff (srst)
    (mode == IRC_HOST && oscEnd && !accept) |=> refreshActive && mode == IRC_REFRESH)
    else $error("period ended without entering refresh");

  chk_row_write: assert property (@(posedge ref_clk) disable iff (srst)
    rowDone |-> ramRdWr == RW_WRITE && ramCsN == CS_OFF)
    else $error("row finished without a deselected write pulse");

  chk_overdue_clear: assert property (@(posedge ref_clk) disable iff (srst)
    $past(sweepDone) |-> !refreshOverdue)
    else $error("overdue kept after a full sweep");

  cov_enter_refresh: cover property (@(posedge ref_clk) disable iff (srst)
    $rose(mode == IRC_REFRESH));

  cov_abort_row: cover property (@(posedge ref_clk) disable iff (srst)
    mode == IRC_REFRESH && accept);

  cov_full_sweep: cover property (@(posedge ref_clk) disable iff (srst)
    sweepDone);

  cov_host_write: cover property (@(posedge ref_clk) disable iff (srst)
    !refreshActive && !ramRdWr);

  cov_overdue: cover property (@(posedge ref_clk) disable iff (srst)
    $rose(refreshOverdue));

endmodule : irc_refresh_controller

// [test/invisible_dram_refresh_controller_tb.sv]
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module invisible_dram_refresh_controller_tb
  import irc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              ref_clk      = 1'b0;
  logic              srst         = 1'b1;
  logic [ADDR_W-1:0] hostAddr     = 11'h000;
  logic              boardSelectN = 1'b1;
  logic              hostRdWr     = 1'b1;
  logic              clearMask    = 1'b1;
  wire  [ROW_W-1:0]  ramRow;
  wire  [COL_W-1:0]  ramCol;
  wire  [CS_W-1:0]   ramCsN;
  wire               ramRdWr;
  wire               refreshActive;
  wire               addressChangeLineN;
  wire               sweepDone;
  wire               refreshOverdue;
  wire  [31:0]       refreshMask;
  localparam int     TB_WINDOW    = 2000;
  int                failures     = 0;
  int                checks       = 0;

  always #2.5 ref_clk = ~ref_clk;

  irc_refresh_controller #(.WINDOW_CYCLES(TB_WINDOW)) irc_refresh_controller_i (
    .ref_clk(ref_clk), .srst(srst), .hostAddr(hostAddr), .boardSelectN(boardSelectN),
    .hostRdWr(hostRdWr), .ramRow(ramRow), .ramCol(ramCol), .ramCsN(ramCsN), .ramRdWr(ramRdWr),
    .refreshActive(refreshActive), .addressChangeLineN(addressChangeLineN),
    .sweepDone(sweepDone), .refreshOverdue(refreshOverdue));

  irc_ram_array_model irc_ram_array_model_i (
    .ref_clk(ref_clk), .clearMask(clearMask), .ramRow(ramRow), .ramCsN(ramCsN),
    .ramRdWr(ramRdWr), .refreshMask(refreshMask));

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  task automatic test_host_access();
    hostAddr = {1'b1, 5'h09, 5'h05};
    tick(6);
    `CHK(addressChangeLineN, 1'b0)
    `CHK(ramRow, ROW_ZERO)
    boardSelectN = 1'b0;
    tick(6);
    `CHK(addressChangeLineN, 1'b1)
    `CHK(ramRow, 5'h05)
    `CHK(ramCol, 5'h09)
    `CHK(ramCsN, CS_BANK1)
    `CHK(refreshActive, 1'b0)
    hostRdWr = RW_WRITE;
    tick(4);
    `CHK(ramRdWr, RW_WRITE)
    // Change during a host write pulse must wait
    hostAddr = {1'b0, 5'h03, 5'h0a};
    tick(6);
    `CHK(ramRow, 5'h05)
    `CHK(addressChangeLineN, 1'b0)
    hostRdWr = RW_READ;
    tick(6);
    `CHK(ramRow, 5'h0a)
    `CHK(ramCsN, CS_BANK0)
    $display("test_host_access done");
  endtask : test_host_access

  task automatic test_refresh_entry();
    int n;
    hostAddr = {1'b0, 5'h04, 5'h11};
    for (n = 0; n < 100 && refreshActive !== 1'b1; n++)
      tick(1);
    clearMask = 1'b0;
    `CHK((n >= OSC_CYC) && (n <= OSC_CYC + 5), 1'b1)
    `CHK(ramCsN, CS_OFF)
    $display("test_refresh_entry done");
  endtask : test_refresh_entry

  task automatic test_sweep();
    int n;
    for (n = 0; n < 33 * OSC_CYC && sweepDone !== 1'b1; n++)
      tick(1);
    `CHK(n > 31 * OSC_CYC, 1'b1)
    `CHK(refreshMask, 32'hffffffff)
    `CHK(refreshActive, 1'b1)
    tick(3);
    `CHK(ramRow, ROW_ZERO)
    $display("test_sweep done");
  endtask : test_sweep

  task automatic test_interrupt();
    int               n;
    logic [ROW_W-1:0] held;
    for (n = 0; n < 100 && ramRow === ROW_ZERO; n++)
      tick(1);
    held = ramRow;
    // Early in the row, so the read phase still admits the change
    hostAddr = {1'b0, 5'h07, 5'h1e};
    tick(8);
    `CHK(refreshActive, 1'b0)
    `CHK(ramRow, 5'h1e)
    for (n = 0; n < 100 && refreshActive !== 1'b1; n++)
      tick(1);
    tick(2);
    `CHK(ramRow, held)
    $display("test_interrupt done");
  endtask : test_interrupt

  task automatic test_overdue();
    int n;
    // Steady reads every 20 cycles keep refresh out until the window runs out
    for (n = 0; n < 120 && refreshOverdue !== 1'b1; n++)
    begin
      hostAddr = hostAddr ^ 11'h001;
      tick(20);
    end
    `CHK(refreshOverdue, 1'b1)
    `CHK(n * 20 <= TB_WINDOW, 1'b1)
    `CHK(refreshActive, 1'b0)
    // Host now holds its address so refresh runs from the held row on to the wrap after row 31
    for (n = 0; n < 34 * OSC_CYC && sweepDone !== 1'b1; n++)
      tick(1);
    tick(2);
    `CHK(refreshOverdue, 1'b0)
    `CHK(refreshActive, 1'b1)
    $display("test_overdue done");
  endtask : test_overdue

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    tick(3);
    test_host_access();
    test_refresh_entry();
    test_sweep();
    test_interrupt();
    test_overdue();
    give_verdict();
  end

  // Two sweeps and one overdue window; the whole run well under 20000
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    give_verdict();
  end
endmodule : invisible_dram_refresh_controller_tb

// [test/irc_ram_array_model.sv]
`timescale 1ns/1ps
module irc_ram_array_model
  import irc_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             clearMask,
  input  wire logic [ROW_W-1:0] ramRow,
  input  wire logic [CS_W-1:0]  ramCsN,
  input  wire logic             ramRdWr,
  output logic      [31:0]      refreshMask
);
  // ----------------------------------------------------------------
  // Rows restored by deselected write pulses
  // ----------------------------------------------------------------
  // No cell data kept: a deselected write only restores what is stored
  logic prevRdWr = 1'b1;

  always @(posedge ref_clk)
  begin
    prevRdWr <= ramRdWr;
    if (clearMask)
      refreshMask <= 32'h0;
    else if (prevRdWr && !ramRdWr && ramCsN == CS_OFF)
      refreshMask[ramRow] <= 1'b1;
  end
endmodule : irc_ram_array_model
